// ---- core/ebpf_pkg.sv ----
// Package holding register map, field positions and reset values of the external bus pin control.
package ebpf_pkg;
  localparam int unsigned ADDR_W = 24;
  // Printed byte offsets of the documented registers.
  localparam logic [23:0] PORT_D_DIRECTION_OFS = 24'hFFFB8C;
  localparam logic [23:0] PORT_E_DIRECTION_OFS = 24'hFFFB8D;
  localparam logic [23:0] CHIP_SELECT_ENABLES_OFS = 24'hFFFBC0;
  localparam logic [23:0] AREA_BUS_WIDTH_OFS = 24'hFFFD84;
  localparam logic [23:0] AREA_ACCESS_STATES_OFS = 24'hFFFD86;
  localparam logic [23:0] AREA_WAIT_CYCLES_OFS = 24'hFFFD8A;
  localparam logic [23:0] READ_STROBE_NEGATION_TIMING_OFS = 24'hFFFD8C;
  // Offsets for registers without a printed address.
  localparam logic [23:0] SELECT_PIN_AND_STROBE_ENABLE_OFS = 24'hFFFBC2;
  localparam logic [23:0] UPPER_ADDRESS_ENABLES_OFS = 24'hFFFBC4;
  localparam logic [23:0] WRITE_STROBE_PIN_ENABLE_OFS = 24'hFFFBC6;
  // Field positions.
  localparam int unsigned AREA2_SELECT_PIN_CHOICE_BIT = 6;
  localparam int unsigned DIRECTION_STROBE_ENABLE_BIT = 2;
  localparam int unsigned LOW_BYTE_WRITE_STROBE_ENABLE_BIT = 6;
  localparam int unsigned AREA2_IDX = 2;
  localparam int unsigned AREA1_IDX = 1;
  localparam int unsigned AREA0_IDX = 0;
  localparam int unsigned UPPER_ADDR_LSB = 16;
  localparam int unsigned UPPER_ADDR_N = 5;
  // Reset values.
  localparam logic [7:0] CS_ENABLES_RST_ROMLESS = 8'h01;
  localparam logic [7:0] CS_ENABLES_RST_ROM = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [15:0] AREA_BUS_WIDTH_RST = 16'h0000;
  localparam logic [15:0] AREA_ACCESS_STATES_RST = 16'h0000;
  localparam logic [15:0] AREA_WAIT_CYCLES_RST = 16'h0000;
  localparam logic [15:0] READ_STROBE_NEGATION_TIMING_RST = 16'h0000;
endpackage : ebpf_pkg

// ---- core/ebpf_reg8.sv ----
// Register of W bits (8 by default) with synchronous reset value and write strobe.
`timescale 1ns/1ps
module ebpf_reg8 #(
  parameter int unsigned W = 8
) (
  input wire logic i_core_clk, // Bus clock.
  input wire logic i_rst_n, // Synchronous reset, active low.
  input wire logic [W-1:0] i_rst_val, // Value taken at reset.
  input wire logic i_wr, // Write strobe for this register.
  input wire logic [W-1:0] i_wdata, // Write data.
  output logic [W-1:0] o_q // Stored value.
);
  // The reset value is a constant wired at the instance, never a live signal.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_q <= i_rst_val;
    end else if (i_wr) begin
      o_q <= i_wdata;
    end
  end
endmodule : ebpf_reg8

// ---- core/ebpf_cs_route.sv ----
// Routing of the eight area chip-selects onto port B pins, merging shared pins.
`timescale 1ns/1ps
module ebpf_cs_route (
  input wire logic [7:0] i_area_active, // One-hot active area, high while accessed.
  input wire logic [7:0] i_cs_en, // Chip-select enables per area.
  input wire logic i_cs2_alt, // Area 2 select placed on the alternate pin.
  output logic [7:0] o_cs_n, // Per-area select, low while accessed.
  output logic o_pin_b1_n, // Merged select on port B pin one.
  output logic o_pin_b2_n, // Merged select on port B pin two.
  output logic [7:0] o_cs_oe // Output enable per area.
);
  wire logic b1_act;
  wire logic b2_act;
  assign o_cs_n = ~i_area_active;
  assign o_cs_oe = i_cs_en;
  // Any mapped area drives the shared pin low.
  assign b1_act = (i_cs_en[ebpf_pkg::AREA1_IDX] & i_area_active[ebpf_pkg::AREA1_IDX])
    | (i_cs_en[ebpf_pkg::AREA2_IDX] & i_cs2_alt & i_area_active[ebpf_pkg::AREA2_IDX]);
  assign b2_act = i_cs_en[ebpf_pkg::AREA2_IDX] & ~i_cs2_alt
    & i_area_active[ebpf_pkg::AREA2_IDX];
  assign o_pin_b1_n = ~b1_act;
  assign o_pin_b2_n = ~b2_act;
endmodule : ebpf_cs_route

// ---- core/ebpf_top.sv ----
// External bus pin function control: registers, pin routing and area settings.
`timescale 1ns/1ps
// Summary of operation
// - Eight chip-select enable bits 7..0 each route one area select to its pin.
// - An enabled bit makes the pin a chip-select output, a clear bit leaves it a port pin.
// - Bit 6 of the pin-select register puts area 2 select on port B pin two when 0, pin one when 1.
// - The read/write direction output is driven only while enable bit 2 is set.
// - Bits 4..0 enable upper address outputs 20..16.
// - Bit 6 of the strobe register turns port A pin four into the low-byte write strobe.
// - All-ones port D and E direction values make the sixteen pins low address outputs.
// - A bus width bit per area selects 16-bit access.
// - An access-state bit per area selects three-cycle instead of two-cycle access.
// - The wait register holds a programmed wait count per area.
// - The read-strobe timing register sets read strobe negation per area.
// - Each chip-select is low while its area is accessed and high otherwise.
// - Selects merged on one pin drive it low when any mapped area is accessed.
// - After reset without on-chip ROM only area 0 select is an output.
module ebpf_top (
  input wire logic i_core_clk, // Bus clock, 20 MHz.
  input wire logic i_rst_n, // Synchronous reset, active low.
  input wire logic i_rom_enabled, // Strap: on-chip ROM enabled.
  input wire logic [23:0] i_addr, // Register address.
  input wire logic [15:0] i_wdata, // Register write data.
  input wire logic i_wr, // Write strobe.
  input wire logic i_rd, // Read strobe.
  output logic [15:0] o_rdata, // Read data, one cycle after the strobe.
  input wire logic [7:0] i_area_active, // One-hot area under external access.
  input wire logic i_bus_write, // Current access direction is write.
  input wire logic [23:0] i_bus_addr, // Current external address.
  output logic [7:0] o_cs_n, // Per-area chip-select, low active.
  output logic [7:0] o_cs_oe, // Chip-select pin output enables.
  output logic o_pin_b1_n, // Merged select on port B pin one.
  output logic o_pin_b2_n, // Merged select on port B pin two.
  output logic o_rdwr, // Read/write direction, high on read.
  output logic o_rdwr_oe, // Direction output enable.
  output logic [4:0] o_upper_addr, // Upper address 20..16.
  output logic [4:0] o_upper_addr_oe, // Upper address enables.
  output logic [15:0] o_low_addr, // Low address on ports D and E.
  output logic [15:0] o_low_addr_oe, // Port D and E direction bits.
  output logic o_low_byte_write_strobe_oe, // Port A pin four is strobe.
  output logic [7:0] o_area_wide, // Per-area 16-bit width.
  output logic [7:0] o_area_three_state, // Per-area three-cycle access.
  output logic [15:0] o_area_wait_cycles, // Wait configuration.
  output logic [15:0] o_read_strobe_timing // Read strobe negation timing.
);
  wire logic wr_pd = i_wr && (i_addr == ebpf_pkg::PORT_D_DIRECTION_OFS);
  wire logic wr_pe = i_wr && (i_addr == ebpf_pkg::PORT_E_DIRECTION_OFS);
  wire logic wr_cse = i_wr && (i_addr == ebpf_pkg::CHIP_SELECT_ENABLES_OFS);
  wire logic wr_ps = i_wr && (i_addr == ebpf_pkg::SELECT_PIN_AND_STROBE_ENABLE_OFS);
  wire logic wr_ua = i_wr && (i_addr == ebpf_pkg::UPPER_ADDRESS_ENABLES_OFS);
  wire logic wr_ws = i_wr && (i_addr == ebpf_pkg::WRITE_STROBE_PIN_ENABLE_OFS);
  wire logic wr_bw = i_wr && (i_addr == ebpf_pkg::AREA_BUS_WIDTH_OFS);
  wire logic wr_as = i_wr && (i_addr == ebpf_pkg::AREA_ACCESS_STATES_OFS);
  wire logic wr_wc = i_wr && (i_addr == ebpf_pkg::AREA_WAIT_CYCLES_OFS);
  wire logic wr_rn = i_wr && (i_addr == ebpf_pkg::READ_STROBE_NEGATION_TIMING_OFS);

  logic [7:0] port_d_direction_r;
  logic [7:0] port_e_direction_r;
  logic [7:0] chip_select_enables_r;
  logic [7:0] select_pin_r;
  logic [7:0] upper_addr_en_r;
  logic [7:0] write_strobe_en_r;
  logic [15:0] bus_width_r;
  logic [15:0] access_states_r;
  logic [15:0] wait_cycles_r;
  logic [15:0] rd_timing_r;
  logic rom_strap_r;
  logic in_reset_r;
  logic [15:0] rdata_nxt;
  logic [15:0] rdata_r;

  ebpf_reg8 #(.W(8)) u_pd (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_rst_val(ebpf_pkg::BYTE_RST), .i_wr(wr_pd), .i_wdata(i_wdata[7:0]),
    .o_q(port_d_direction_r));
  ebpf_reg8 #(.W(8)) u_pe (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_rst_val(ebpf_pkg::BYTE_RST), .i_wr(wr_pe), .i_wdata(i_wdata[7:0]),
    .o_q(port_e_direction_r));
  ebpf_reg8 #(.W(8)) u_ps (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_rst_val(ebpf_pkg::BYTE_RST), .i_wr(wr_ps), .i_wdata(i_wdata[7:0]),
    .o_q(select_pin_r));
  ebpf_reg8 #(.W(8)) u_ua (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_rst_val(ebpf_pkg::BYTE_RST), .i_wr(wr_ua), .i_wdata(i_wdata[7:0]),
    .o_q(upper_addr_en_r));
  ebpf_reg8 #(.W(8)) u_ws (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_rst_val(ebpf_pkg::BYTE_RST), .i_wr(wr_ws), .i_wdata(i_wdata[7:0]),
    .o_q(write_strobe_en_r));
  ebpf_reg8 #(.W(16)) u_bw (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_rst_val(ebpf_pkg::AREA_BUS_WIDTH_RST), .i_wr(wr_bw), .i_wdata(i_wdata),
    .o_q(bus_width_r));
  ebpf_reg8 #(.W(16)) u_as (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_rst_val(ebpf_pkg::AREA_ACCESS_STATES_RST), .i_wr(wr_as), .i_wdata(i_wdata),
    .o_q(access_states_r));
  ebpf_reg8 #(.W(16)) u_wc (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_rst_val(ebpf_pkg::AREA_WAIT_CYCLES_RST), .i_wr(wr_wc), .i_wdata(i_wdata),
    .o_q(wait_cycles_r));
  ebpf_reg8 #(.W(16)) u_rn (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_rst_val(ebpf_pkg::READ_STROBE_NEGATION_TIMING_RST), .i_wr(wr_rn),
    .i_wdata(i_wdata), .o_q(rd_timing_r));

  // The chip-select enables take their reset value from the ROM strap, which is only
  // caught by a clocked process, so the strap is latched while reset is held and the
  // register is loaded with the matching constant in the first cycle after release.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      rom_strap_r <= i_rom_enabled;
      in_reset_r <= 1'b1;
    end else begin
      in_reset_r <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      chip_select_enables_r <= ebpf_pkg::CS_ENABLES_RST_ROM;
    end else if (in_reset_r && !wr_cse) begin
      chip_select_enables_r <= rom_strap_r ? ebpf_pkg::CS_ENABLES_RST_ROM
        : ebpf_pkg::CS_ENABLES_RST_ROMLESS;
    end else if (wr_cse) begin
      chip_select_enables_r <= i_wdata[7:0];
    end
  end

  ebpf_cs_route u_route (
    .i_area_active(i_area_active),
    .i_cs_en(chip_select_enables_r),
    .i_cs2_alt(select_pin_r[ebpf_pkg::AREA2_SELECT_PIN_CHOICE_BIT]),
    .o_cs_n(o_cs_n),
    .o_pin_b1_n(o_pin_b1_n),
    .o_pin_b2_n(o_pin_b2_n),
    .o_cs_oe(o_cs_oe)
  );

  assign o_rdwr = ~i_bus_write;
  assign o_rdwr_oe = select_pin_r[ebpf_pkg::DIRECTION_STROBE_ENABLE_BIT];
  assign o_upper_addr = i_bus_addr[ebpf_pkg::UPPER_ADDR_LSB +: ebpf_pkg::UPPER_ADDR_N];
  assign o_upper_addr_oe = upper_addr_en_r[4:0];
  assign o_low_addr = i_bus_addr[15:0];
  assign o_low_addr_oe = {port_e_direction_r, port_d_direction_r};
  assign o_low_byte_write_strobe_oe =
    write_strobe_en_r[ebpf_pkg::LOW_BYTE_WRITE_STROBE_ENABLE_BIT];
  assign o_area_wide = bus_width_r[7:0];
  assign o_area_three_state = access_states_r[15:8];
  assign o_area_wait_cycles = wait_cycles_r;
  assign o_read_strobe_timing = rd_timing_r;

  // Direction registers are write-only and read as zero, as does any unmapped address.
  assign rdata_nxt =
    !i_rd ? 16'h0000 :
    (i_addr == ebpf_pkg::CHIP_SELECT_ENABLES_OFS) ? {8'h00, chip_select_enables_r} :
    (i_addr == ebpf_pkg::SELECT_PIN_AND_STROBE_ENABLE_OFS) ? {8'h00, select_pin_r} :
    (i_addr == ebpf_pkg::UPPER_ADDRESS_ENABLES_OFS) ? {8'h00, upper_addr_en_r} :
    (i_addr == ebpf_pkg::WRITE_STROBE_PIN_ENABLE_OFS) ? {8'h00, write_strobe_en_r} :
    (i_addr == ebpf_pkg::AREA_BUS_WIDTH_OFS) ? bus_width_r :
    (i_addr == ebpf_pkg::AREA_ACCESS_STATES_OFS) ? access_states_r :
    (i_addr == ebpf_pkg::AREA_WAIT_CYCLES_OFS) ? wait_cycles_r :
    (i_addr == ebpf_pkg::READ_STROBE_NEGATION_TIMING_OFS) ? rd_timing_r :
    16'h0000;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end
  assign o_rdata = rdata_r;
endmodule : ebpf_top

// ---- verif/ebpf_props.sv ----
// Checker of the external bus pin control ports.
`timescale 1ns/1ps
module ebpf_props (
  input wire logic i_core_clk, // Clock.
  input wire logic i_rst_n, // Reset.
  input wire logic i_rom_enabled, // Strap.
  input wire logic [23:0] i_addr, // Address.
  input wire logic [15:0] i_wdata, // Data.
  input wire logic i_wr, // Write.
  input wire logic [7:0] i_area_active, // Area.
  input wire logic [7:0] o_cs_n, // Selects.
  input wire logic [7:0] o_cs_oe, // Enables.
  input wire logic o_pin_b1_n, // Pin one.
  input wire logic o_pin_b2_n, // Pin two.
  input wire logic o_rdwr_oe, // Direction.
  input wire logic [4:0] o_upper_addr_oe, // Upper.
  input wire logic o_low_byte_write_strobe_oe // Strobe.
);
  wire w_cs = i_addr == ebpf_pkg::CHIP_SELECT_ENABLES_OFS;
  wire w_sel = i_addr == ebpf_pkg::SELECT_PIN_AND_STROBE_ENABLE_OFS;
  wire w_up = i_addr == ebpf_pkg::UPPER_ADDRESS_ENABLES_OFS;
  wire w_ws = i_addr == ebpf_pkg::WRITE_STROBE_PIN_ENABLE_OFS;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  a_cs_enable_write: assert property (i_wr && w_cs |=> o_cs_oe == $past(i_wdata[7:0]))
    else $error("select enables did not follow the write");
  a_cs_active_low: assert property (o_cs_n == ~i_area_active)
    else $error("area select wrong for the active area");
  a_pin_b1_merge: assert property (i_area_active[1] && o_cs_oe[1] |-> !o_pin_b1_n)
    else $error("pin one not low for area one");
  a_pin_b2_owner: assert property (!o_pin_b2_n |-> i_area_active[2] && o_pin_b1_n)
    else $error("pin two low without area two");
  a_strobe_dir_en: assert property (i_wr && w_sel |=> o_rdwr_oe == $past(i_wdata[2]))
    else $error("direction enable did not follow the write");
  a_upper_addr_en: assert property (i_wr && w_up |=> o_upper_addr_oe == $past(i_wdata[4:0]))
    else $error("upper address enables did not follow the write");
  a_write_strobe_en: assert property (i_wr && w_ws |=>
    o_low_byte_write_strobe_oe == $past(i_wdata[6]))
    else $error("strobe pin enable did not follow the write");
  a_rst_selects: assert property ($rose(i_rst_n) && !i_wr |=>
    o_cs_oe == (i_rom_enabled ? ebpf_pkg::CS_ENABLES_RST_ROM : ebpf_pkg::CS_ENABLES_RST_ROMLESS))
    else $error("select enables wrong after reset");
  c_merge_b1: cover property (!o_pin_b1_n && i_area_active[2]);
  c_pin_b2: cover property (!o_pin_b2_n);
  c_cs_write: cover property (i_wr && w_cs);
endmodule : ebpf_props

// ---- verif/ebpf_mem_model.sv ----
// Model of the external memories selected on port B pins one and two.
`timescale 1ns/1ps
module ebpf_mem_model (
  input wire logic i_sel_b1_n, // Select on pin one.
  input wire logic i_sel_b2_n, // Select on pin two.
  output logic [1:0] o_hit // Device answering.
);
  // The memory on pin one serves area 1, and area 2 too while pin-select bit 6 is set; the memory on pin two serves area 2 otherwise.
  assign o_hit = {~i_sel_b2_n, ~i_sel_b1_n};
endmodule : ebpf_mem_model

// ---- verif/ebpf_top_test.sv ----
// Self-checking testbench of the external bus pin control.
`timescale 1ns/1ps
module ebpf_top_test;
  logic i_core_clk = 0, i_rst_n = 0, i_rom_enabled = 0, i_wr = 0, i_rd = 0, i_bus_write = 0;
  logic [23:0] i_addr = 0, i_bus_addr = 0;
  logic [15:0] i_wdata = 0, o_rdata, o_area_wait_cycles, o_read_strobe_timing;
  logic [15:0] o_low_addr, o_low_addr_oe;
  logic [7:0] i_area_active = 0, o_cs_n, o_cs_oe, o_area_wide, o_area_three_state, d;
  logic [4:0] o_upper_addr, o_upper_addr_oe;
  logic o_pin_b1_n, o_pin_b2_n, o_rdwr, o_rdwr_oe, o_low_byte_write_strobe_oe;
  logic [1:0] hit, e;
  int n_mismatch = 0;
  int compares = 0;
  ebpf_top u_ebpf_top (.*);
  ebpf_mem_model u_ebpf_mem_model (.i_sel_b1_n(o_pin_b1_n), .i_sel_b2_n(o_pin_b2_n), .o_hit(hit));
  initial forever #25 i_core_clk = ~i_core_clk;
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(logic [23:0] a, logic [15:0] v);
    @(posedge i_core_clk);
    i_wr <= 1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_core_clk);
    i_wr <= 0;
    #1;
  endtask : wr
  task automatic rd(logic [23:0] a, logic [15:0] exp, string what);
    @(posedge i_core_clk);
    i_rd <= 1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 0;
    #1 chk(what, exp, o_rdata);
  endtask : rd
  function automatic logic [1:0] pins(logic [7:0] en, logic ch, logic [7:0] act);
    return {!(en[2] && !ch && act[2]), !((en[1] && act[1]) || (en[2] && ch && act[2]))};
  endfunction : pins
  task automatic end_of_test;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test
  // A hung run still reaches the verdict.
  initial begin
    #1ms;
    n_mismatch++;
    end_of_test;
  end
  initial begin
    void'($urandom(32'hB8376D36));
    repeat (6) @(posedge i_core_clk);
    i_rst_n <= 1;
    @(posedge i_core_clk);
    #1 chk("cs_oe reset", 16'h0001, {8'h00, o_cs_oe});
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom) | 8'(1 << i);
      wr(ebpf_pkg::CHIP_SELECT_ENABLES_OFS, {8'($urandom), d});
      chk("cs_oe", {8'h00, d}, {8'h00, o_cs_oe});
      rd(ebpf_pkg::CHIP_SELECT_ENABLES_OFS, {8'h00, d}, "cs read");
    end
    $display("test enables done");
    for (int k = 0; k < 16; k++) begin
      d = 8'($urandom) | (k[1] ? 8'h06 : 8'h00);
      wr(ebpf_pkg::SELECT_PIN_AND_STROBE_ENABLE_OFS, {9'h000, k[0], 6'h00});
      wr(ebpf_pkg::CHIP_SELECT_ENABLES_OFS, {8'h00, d});
      for (int a = 0; a < 8; a++) begin
        @(posedge i_core_clk);
        i_area_active <= 8'(1 << a);
        i_bus_addr <= 24'($urandom);
        i_bus_write <= a[0];
        #1 e = pins(d, k[0], 8'(1 << a));
        chk("cs_n", {8'h00, ~(8'(1 << a))}, {8'h00, o_cs_n});
        chk("pins", {14'h0, e}, {14'h0, o_pin_b2_n, o_pin_b1_n});
        chk("memory hit", {14'h0, ~e}, {14'h0, hit});
        chk("low addr", i_bus_addr[15:0], o_low_addr);
        chk("upper addr", {11'h000, i_bus_addr[20:16]}, {11'h000, o_upper_addr});
        chk("rdwr", {15'h0000, ~a[0]}, {15'h0000, o_rdwr});
      end
    end
    @(posedge i_core_clk);
    i_area_active <= 8'h00;
    $display("test routing done");
    for (int i = 0; i < 6; i++) begin
      d = 8'($urandom);
      wr(ebpf_pkg::SELECT_PIN_AND_STROBE_ENABLE_OFS, {8'h00, d});
      wr(ebpf_pkg::UPPER_ADDRESS_ENABLES_OFS, {8'h00, d});
      wr(ebpf_pkg::WRITE_STROBE_PIN_ENABLE_OFS, {8'h00, d});
      chk("pin enables", {8'h00, d[6], d[2], 1'b0, d[4:0]},
          {8'h00, o_low_byte_write_strobe_oe, o_rdwr_oe, 1'b0, o_upper_addr_oe});
    end
    $display("test pin enables done");
    wr(ebpf_pkg::READ_STROBE_NEGATION_TIMING_OFS, 16'hFFFF);
    chk("read strobe", 16'hFFFF, o_read_strobe_timing);
    wr(ebpf_pkg::AREA_BUS_WIDTH_OFS, 16'h00FF);
    wr(ebpf_pkg::AREA_ACCESS_STATES_OFS, 16'hFF00);
    wr(ebpf_pkg::AREA_WAIT_CYCLES_OFS, 16'h0770);
    wr(ebpf_pkg::READ_STROBE_NEGATION_TIMING_OFS, 16'h0000);
    chk("width", 16'h00FF, {8'h00, o_area_wide});
    chk("three state", 16'h00FF, {8'h00, o_area_three_state});
    chk("wait", 16'h0770, o_area_wait_cycles);
    chk("read strobe", 16'h0000, o_read_strobe_timing);
    rd(ebpf_pkg::AREA_WAIT_CYCLES_OFS, 16'h0770, "wait read");
    @(posedge i_core_clk);
    #1 chk("rdata after read", 16'h0000, o_rdata);
    wr(ebpf_pkg::PORT_D_DIRECTION_OFS, 16'h00FF);
    wr(ebpf_pkg::PORT_E_DIRECTION_OFS, 16'h00FF);
    chk("low addr oe", 16'hFFFF, o_low_addr_oe);
    rd(ebpf_pkg::PORT_D_DIRECTION_OFS, 16'h0000, "direction read");
    rd(24'h000123, 16'h0000, "unmapped read");
    $display("test area settings done");
    @(posedge i_core_clk);
    i_rom_enabled <= 1;
    i_rst_n <= 0;
    repeat (6) @(posedge i_core_clk);
    i_rst_n <= 1;
    @(posedge i_core_clk);
    #1 chk("cs_oe rom reset", 16'h0000, {8'h00, o_cs_oe});
    chk("wait reset", ebpf_pkg::AREA_WAIT_CYCLES_RST, o_area_wait_cycles);
    chk("direction reset", 16'h0000, o_low_addr_oe);
    $display("test second reset done");
    end_of_test;
  end
endmodule : ebpf_top_test
bind ebpf_top ebpf_props u_ebpf_props (.i_core_clk, .i_rst_n, .i_rom_enabled, .i_addr, .i_wdata,
  .i_wr, .i_area_active, .o_cs_n, .o_cs_oe, .o_pin_b1_n, .o_pin_b2_n, .o_rdwr_oe,
  .o_upper_addr_oe, .o_low_byte_write_strobe_oe);
